// ==== hw/sccs_regs.vh ====
// Field layout, reset value and address map of the channel comm settings registers
`ifndef SCCS_REGS_VH
`define SCCS_REGS_VH
`define SCCS_RESET_VAL 16'h0087
`define SCCS_TX_EN_BIT 15
`define SCCS_RX_EN_BIT 14
`define SCCS_DAP_BIT 13
`define SCCS_CKP_BIT 12
`define SCCS_ZERO11_BIT 11
`define SCCS_EOC_BIT 10
`define SCCS_PTC_HI_BIT 9
`define SCCS_PTC_LO_BIT 8
`define SCCS_DIR_BIT 7
`define SCCS_ZERO6_BIT 6
`define SCCS_SLC_HI_BIT 5
`define SCCS_SLC_LO_BIT 4
`define SCCS_ZERO3_BIT 3
`define SCCS_ONE2_BIT 2
`define SCCS_DLS_HI_BIT 1
`define SCCS_DLS_LO_BIT 0
// Byte addresses, 20-bit space, even word addresses
`define SCCS_ADDR_CH00 20'hF0118
`define SCCS_ADDR_CH01 20'hF011A
`define SCCS_ADDR_CH02 20'hF011C
`define SCCS_ADDR_CH03 20'hF011E
`define SCCS_ADDR_CH10 20'hF0158
`define SCCS_ADDR_CH11 20'hF015A
// Channel index within the bank
`define SCCS_IDX_CH00 3'h0
`define SCCS_IDX_CH01 3'h1
`define SCCS_IDX_CH02 3'h2
`define SCCS_IDX_CH03 3'h3
`define SCCS_IDX_CH10 3'h4
`define SCCS_IDX_CH11 3'h5
`define SCCS_IDX_NONE 3'h7
// Channels with two-bit stop field: 00, 02, 10; with writable upper length bit: 00, 01
`define SCCS_STOP2_MASK 6'h15
`define SCCS_DLS1_MASK 6'h03
// Field codes
`define SCCS_PAR_NONE 2'h0
`define SCCS_PAR_ZERO 2'h1
`define SCCS_PAR_EVEN 2'h2
`define SCCS_PAR_ODD 2'h3
`define SCCS_STOP_NONE 2'h0
`define SCCS_STOP_ONE 2'h1
`define SCCS_STOP_TWO 2'h2
`define SCCS_LEN_9 2'h1
`define SCCS_LEN_7 2'h2
`define SCCS_LEN_8 2'h3
`define SCCS_NCH 6
`endif

// ==== hw/sccs_bank.v ====
// Communication settings register bank of the six serial channels
//
// Contract
// - Register written as one 16-bit word
// - Reset value is 0x0087
// - Bits 15:14 select off, rx, tx, both
// - Bits 13:12 give clocked-serial phase type 1-4
// - Mask clear: errors raise receive-end interrupt
// - Mask set: error interrupt, no receive-end
// - Clocked-serial with mask set may raise error
// - Transmit parity none, zero, even, odd
// - Receive parity none, unchecked, even, odd
// - Bit 5 exists on channels 00,02,10 only
// - Stop codes none, one, two; 11 prohibited
// - Length codes 9,7,8 bits; upper bit writable on 00,01 only
// - Zero parity bit always zero
`timescale 1ns/100ps
`include "sccs_regs.vh"

module sccs_bank (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // CPU register bus, 16-bit word access
  input wire [19:0] bus_addr_i,
  input wire bus_wr_i,
  input wire bus_rd_i,
  input wire [15:0] bus_wdata_i,
  output reg [15:0] bus_rdata_o,
  output reg bus_wr_ignored_o,
  // Channel state from the shift controllers, one bit per channel
  input wire [5:0] channel_running_flag_i,
  input wire [5:0] rx_error_i,
  input wire [5:0] rx_done_i,
  input wire [5:0] tx_parity_data_i,
  // Decoded per-channel controls
  output reg [5:0] transmit_enable_bit_o,
  output reg [5:0] receive_enable_bit_o,
  output reg [11:0] phase_type_o,
  output reg [5:0] bit_order_flag_o,
  output reg [11:0] parity_mode_o,
  output reg [5:0] parity_check_o,
  output reg [5:0] tx_parity_bit_o,
  output reg [11:0] stop_len_o,
  output reg [11:0] word_len_o,
  // Interrupt strobes
  output reg [5:0] serial_error_irq_o,
  output reg [5:0] receive_end_irq_o
);

  // Settings storage, one word per channel
  reg [15:0] comm_settings_reg [0:`SCCS_NCH-1];
  // Decoded channel index of the current address
  wire [2:0] sel_idx;
  // Read data mux output
  reg [15:0] rdata_next;
  integer k;

  // Address decode, shared by reads and writes
  function [2:0] sccs_decode;
    input [19:0] addr;
    begin
      case (addr)
        `SCCS_ADDR_CH00: sccs_decode = `SCCS_IDX_CH00;
        `SCCS_ADDR_CH01: sccs_decode = `SCCS_IDX_CH01;
        `SCCS_ADDR_CH02: sccs_decode = `SCCS_IDX_CH02;
        `SCCS_ADDR_CH03: sccs_decode = `SCCS_IDX_CH03;
        `SCCS_ADDR_CH10: sccs_decode = `SCCS_IDX_CH10;
        `SCCS_ADDR_CH11: sccs_decode = `SCCS_IDX_CH11;
        default: sccs_decode = `SCCS_IDX_NONE;
      endcase
    end
  endfunction

  // Fixed bits forced so they always read at their fixed values: 11,6,3 low, 2 high,
  // bit 5 only where a two-bit stop field exists, bit 1 high except channels 00/01
  function [15:0] sccs_fix;
    input [15:0] w;
    input [2:0] idx;
    reg [15:0] f;
    // Channels that keep the upper stop bit
    reg [5:0] stop2_mask;
    // Channels that keep the upper length bit
    reg [5:0] dls1_mask;
    begin
      // A literal cannot be bit-selected, so the masks are held in variables first
      stop2_mask = `SCCS_STOP2_MASK;
      dls1_mask = `SCCS_DLS1_MASK;
      f = w;
      f[`SCCS_ZERO11_BIT] = 1'b0;
      f[`SCCS_ZERO6_BIT] = 1'b0;
      f[`SCCS_ZERO3_BIT] = 1'b0;
      f[`SCCS_ONE2_BIT] = 1'b1;
      if (!stop2_mask[idx]) begin
        f[`SCCS_SLC_HI_BIT] = 1'b0;
      end
      if (!dls1_mask[idx]) begin
        f[`SCCS_DLS_HI_BIT] = 1'b1;
      end
      sccs_fix = f;
    end
  endfunction

  assign sel_idx = sccs_decode(bus_addr_i);

  // Read mux; unmapped addresses read zero
  always @* begin
    rdata_next = 16'h0000;
    if (sel_idx != `SCCS_IDX_NONE) begin
      rdata_next = comm_settings_reg[sel_idx];
    end
  end

  // Register writes; whole 16-bit word only, refused while the channel runs
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (k = 0; k < `SCCS_NCH; k = k + 1) begin
        comm_settings_reg[k] <= `SCCS_RESET_VAL;
      end
      bus_rdata_o <= 16'h0000;
      bus_wr_ignored_o <= 1'b0;
    end else begin
      bus_wr_ignored_o <= 1'b0;
      if (bus_rd_i) begin
        bus_rdata_o <= rdata_next;
      end
      if (bus_wr_i && sel_idx != `SCCS_IDX_NONE) begin
        // A running channel keeps its settings; the write is dropped and flagged
        if (channel_running_flag_i[sel_idx]) begin
          bus_wr_ignored_o <= 1'b1;
        end else begin
          comm_settings_reg[sel_idx] <= sccs_fix(bus_wdata_i, sel_idx);
        end
      end
    end
  end

  // Next transmit enables, one bit per channel
  wire [5:0] txe_next;
  // Next receive enables
  wire [5:0] rxe_next;
  // Next phase type codes, two bits per channel
  wire [11:0] phase_next;
  // Next bit order flags
  wire [5:0] order_next;
  // Next parity codes, two bits per channel
  wire [11:0] parity_next;
  // Next receive parity check enables
  wire [5:0] check_next;
  // Next transmit parity bits
  wire [5:0] par_bit_next;
  // Next stop codes, two bits per channel
  wire [11:0] stop_next;
  // Next length codes, two bits per channel
  wire [11:0] len_next;
  // Next error interrupt strobes
  wire [5:0] err_irq_next;
  // Next receive-end interrupt strobes
  wire [5:0] end_irq_next;

  // Transmit parity bit of one channel; none and zero codes both give a low bit
  function sccs_par_bit;
    input [1:0] code;
    input data_xor;
    begin
      case (code)
        `SCCS_PAR_EVEN: sccs_par_bit = data_xor;
        `SCCS_PAR_ODD: sccs_par_bit = ~data_xor;
        default: sccs_par_bit = 1'b0;
      endcase
    end
  endfunction

  // Per-channel decode of the stored fields; combinational only, the flops sit below
  genvar g;
  generate
    for (g = 0; g < `SCCS_NCH; g = g + 1) begin : g_ch
      // Stored word of this channel
      wire [15:0] w;
      // Parity code of this channel
      wire [1:0] par;
      // Error interrupt mask of this channel
      wire err_mask;
      assign w = comm_settings_reg[g];
      assign par = {w[`SCCS_PTC_HI_BIT], w[`SCCS_PTC_LO_BIT]};
      assign err_mask = w[`SCCS_EOC_BIT];
      assign txe_next[g] = w[`SCCS_TX_EN_BIT];
      assign rxe_next[g] = w[`SCCS_RX_EN_BIT];
      // Code 0..3 stands for types 1..4; UART/two-wire rely on software zeroing
      assign phase_next[2*g+1:2*g] = {w[`SCCS_DAP_BIT], w[`SCCS_CKP_BIT]};
      assign order_next[g] = w[`SCCS_DIR_BIT];
      assign parity_next[2*g+1:2*g] = par;
      // Only even and odd are checked on reception
      assign check_next[g] = par[1];
      // Zero code forces a zero bit regardless of data
      assign par_bit_next[g] = sccs_par_bit(par, tx_parity_data_i[g]);
      // Prohibited stop code 11 is passed through; controller treats it as undefined
      assign stop_next[2*g+1:2*g] = {w[`SCCS_SLC_HI_BIT], w[`SCCS_SLC_LO_BIT]};
      assign len_next[2*g+1:2*g] = {w[`SCCS_DLS_HI_BIT], w[`SCCS_DLS_LO_BIT]};
      // Error routing; mask set also lets clocked-serial errors through
      assign err_irq_next[g] = rx_error_i[g] & err_mask;
      // A routed error takes the place of the receive end, never both at once
      assign end_irq_next[g] = rx_done_i[g] & ~(rx_error_i[g] & err_mask);
    end
  endgenerate

  // One register stage for all decoded controls; a single process keeps one driver per output
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      // Decode of the reset word: off, type 1, LSB first, no parity, no stop, 8-bit
      transmit_enable_bit_o <= {`SCCS_NCH{1'b0}};
      receive_enable_bit_o <= {`SCCS_NCH{1'b0}};
      phase_type_o <= {`SCCS_NCH{2'h0}};
      bit_order_flag_o <= {`SCCS_NCH{1'b1}};
      parity_mode_o <= {`SCCS_NCH{`SCCS_PAR_NONE}};
      parity_check_o <= {`SCCS_NCH{1'b0}};
      tx_parity_bit_o <= {`SCCS_NCH{1'b0}};
      stop_len_o <= {`SCCS_NCH{`SCCS_STOP_NONE}};
      word_len_o <= {`SCCS_NCH{`SCCS_LEN_8}};
      // No interrupt strobe while held in reset
      serial_error_irq_o <= {`SCCS_NCH{1'b0}};
      receive_end_irq_o <= {`SCCS_NCH{1'b0}};
    end else begin
      // Controls trail the stored words by one cycle
      transmit_enable_bit_o <= txe_next;
      receive_enable_bit_o <= rxe_next;
      phase_type_o <= phase_next;
      bit_order_flag_o <= order_next;
      parity_mode_o <= parity_next;
      parity_check_o <= check_next;
      tx_parity_bit_o <= par_bit_next;
      stop_len_o <= stop_next;
      word_len_o <= len_next;
      // Interrupt strobes stand for one cycle per event
      serial_error_irq_o <= err_irq_next;
      receive_end_irq_o <= end_irq_next;
    end
  end

endmodule // sccs_bank

// ==== tb/sccs_sva.sv ====
// Port timing checker of the comm settings bank
`timescale 1ns/100ps
module sccs_sva (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [19:0] bus_addr_i,
  input wire logic bus_wr_i,
  input wire logic [15:0] bus_wdata_i,
  input wire logic bus_wr_ignored_o,
  // Channel side
  input wire logic [5:0] channel_running_flag_i,
  input wire logic [5:0] rx_error_i,
  input wire logic [5:0] rx_done_i,
  input wire logic [5:0] transmit_enable_bit_o,
  input wire logic [5:0] bit_order_flag_o,
  input wire logic [11:0] parity_mode_o,
  input wire logic [5:0] serial_error_irq_o,
  input wire logic [5:0] receive_end_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Accepted write to channel 00; decode lands two edges later
  sequence wr0; bus_wr_i && bus_addr_i == 20'hF0118 && !channel_running_flag_i[0]; endsequence
  rst_word_a: assert property ($rose(rst_n_i) |-> ##1 bit_order_flag_o == 6'h3F && transmit_enable_bit_o == 6'h00)
    else $error("bad reset decode");
  tx_enable_a: assert property (wr0 |-> ##2 transmit_enable_bit_o[0] == $past(bus_wdata_i[15], 2))
    else $error("bad enable");
  par_mode_a: assert property (wr0 |-> ##2 parity_mode_o[1:0] == $past(bus_wdata_i[9:8], 2))
    else $error("bad parity mode");
  bit_order_a: assert property (wr0 |-> ##2 bit_order_flag_o[0] == $past(bus_wdata_i[7], 2))
    else $error("bad bit order");
  busy_drop_a: assert property (bus_wr_i && bus_addr_i == 20'hF0118 && channel_running_flag_i[0] |=> bus_wr_ignored_o)
    else $error("busy write unflagged");
  err_cause_a: assert property ((serial_error_irq_o & ~$past(rx_error_i)) == 6'h00)
    else $error("stray error irq");
  end_cause_a: assert property ((receive_end_irq_o & ~$past(rx_done_i)) == 6'h00)
    else $error("stray end irq");
  irq_excl_a: assert property ((serial_error_irq_o & receive_end_irq_o) == 6'h00)
    else $error("both irqs");
endmodule // sccs_sva
bind sccs_bank sccs_sva sccs_sva_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i),
  .bus_wdata_i(bus_wdata_i), .bus_wr_ignored_o(bus_wr_ignored_o), .channel_running_flag_i(channel_running_flag_i),
  .rx_error_i(rx_error_i), .rx_done_i(rx_done_i), .transmit_enable_bit_o(transmit_enable_bit_o),
  .bit_order_flag_o(bit_order_flag_o), .parity_mode_o(parity_mode_o), .serial_error_irq_o(serial_error_irq_o),
  .receive_end_irq_o(receive_end_irq_o));

// ==== tb/sccs_peer.sv ====
// Model of the channel shift controllers
`timescale 1ns/100ps
module sccs_peer (
  // Bench commands
  input wire logic [5:0] run_i,
  input wire logic [5:0] err_i,
  input wire logic [5:0] done_i,
  // Status to the bank
  output wire logic [5:0] run_o,
  output wire logic [5:0] err_o,
  output wire logic [5:0] done_o,
  output wire logic [5:0] data_o
);
  assign run_o = run_i;
  // An error only comes with the end of its reception
  assign err_o = err_i & done_i;
  assign done_o = done_i;
  // Odd data parity on channel 00
  assign data_o = 6'h01;
endmodule // sccs_peer

// ==== tb/sccs_bank_tb.sv ====
// Self-checking bench of the comm settings bank
`timescale 1ns/100ps
module sccs_bank_tb;
  logic clk_i = 0, rst_n_i = 0, bus_wr_i = 0, bus_rd_i = 0, ign, bus_wr_ignored_o;
  logic [19:0] bus_addr_i = 0;
  logic [15:0] bus_wdata_i = 0, bus_rdata_o;
  logic [5:0] run = 0, err = 0, done = 0, rf, re, rn, pd, txe, rxe, ord, pc, pb, ei, di;
  logic [11:0] ph, par, stp, len;
  int n_fail = 0, compares = 0;
  logic [19:0] adr [6] = '{20'hF0118, 20'hF011A, 20'hF011C, 20'hF011E, 20'hF0158, 20'hF015A};
  initial forever #5 clk_i = ~clk_i;
  sccs_peer sccs_peer_i (.run_i(run), .err_i(err), .done_i(done), .run_o(rf), .err_o(re), .done_o(rn), .data_o(pd));
  sccs_bank sccs_bank_i (.clk_i, .rst_n_i, .bus_addr_i, .bus_wr_i, .bus_rd_i, .bus_wdata_i, .bus_rdata_o,
    .bus_wr_ignored_o, .channel_running_flag_i(rf), .rx_error_i(re), .rx_done_i(rn), .tx_parity_data_i(pd),
    .transmit_enable_bit_o(txe), .receive_enable_bit_o(rxe), .phase_type_o(ph), .bit_order_flag_o(ord),
    .parity_mode_o(par), .parity_check_o(pc), .tx_parity_bit_o(pb), .stop_len_o(stp), .word_len_o(len),
    .serial_error_irq_o(ei), .receive_end_irq_o(di));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Bus write; the refusal flag is caught while it stands
  task automatic wr(input logic [19:0] a, input logic [15:0] d);
    @(posedge clk_i) #1 {bus_addr_i, bus_wdata_i, bus_wr_i} = {a, d, 1'b1};
    @(posedge clk_i) #1 bus_wr_i = 0;
    ign = bus_wr_ignored_o;
  endtask
  task automatic rd(input logic [19:0] a, input logic [15:0] exp);
    @(posedge clk_i) #1 {bus_addr_i, bus_rd_i} = {a, 1'b1};
    @(posedge clk_i) #1 bus_rd_i = 0;
    chk(bus_rdata_o, exp);
  endtask
  // Stored word: fixed zeros and one, missing stop and length bits
  function automatic logic [15:0] fix(input int c, input logic [15:0] d);
    fix = (d & 16'hF7B7) | 16'h0004;
    if (c % 2 == 1) fix[5] = 1'b0;
    if (c > 1) fix[1] = 1'b1;
  endfunction
  task automatic t_regs;
    wr(20'hF0120, 16'hFFFF);
    rd(20'hF0120, 16'h0000);
    for (int c = 0; c < 6; c++) begin
      rd(adr[c], 16'h0087);
      wr(adr[c], 16'hFFFF);
      rd(adr[c], fix(c, 16'hFFFF));
      // Decoded stop, length and order: upper stop bit only where it exists
      chk({stp[2*c+:2], len[2*c+:2], ord[c]}, {(c % 2 == 0), 1'b1, 2'b11, 1'b1});
      wr(adr[c], 16'h0000);
      rd(adr[c], fix(c, 16'h0000));
      // Upper length bit stays high where it is fixed
      chk({stp[2*c+:2], len[2*c+:2], ord[c]}, {2'b00, (c > 1), 1'b0, 1'b0});
    end
    $display("regs test done");
  endtask
  // Every enable, phase and parity code on channel 00
  task automatic t_codes;
    for (int k = 0; k < 4; k++) begin
      wr(adr[0], 16'h0087 | 16'(k) << 14 | 16'(k) << 12 | 16'(k) << 8);
      repeat (2) @(posedge clk_i);
      #1 chk({txe[0], rxe[0], ph[1:0], par[1:0], pc[0]}, {2'(k), 2'(k), 2'(k), k[1]});
      if (k > 0) chk(pb[0], k == 2);
    end
    $display("codes test done");
  endtask
  // Running channel refuses a write and keeps its word
  task automatic t_busy;
    run = 6'h01;
    wr(adr[0], 16'h4087);
    chk(ign, 1'b1);
    run = 6'h00;
    rd(adr[0], 16'hF387);
    $display("busy test done");
  endtask
  task automatic t_irq;
    for (int m = 0; m < 2; m++) begin
      // UART reception setup: phase and parity zero, mask clear on the first pass, set on the second
      wr(adr[0], 16'h0087 | 16'(m) << 10);
      repeat (2) @(posedge clk_i);
      #1 {err, done} = 12'h041;
      @(posedge clk_i) #1 {err, done} = 12'h000;
      chk({ei[0], di[0]}, {1'(m), 1'(!m)});
    end
    $display("irq test done");
  endtask
  task automatic report_and_stop;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    #1 rst_n_i = 1;
    t_regs;
    t_codes;
    t_busy;
    t_irq;
    report_and_stop;
  end
  // Watchdog well past the hundred or so cycles the tests need
  initial begin
    #20000 n_fail++;
    report_and_stop;
  end
endmodule // sccs_bank_tb
